// ==== shared/fcl_pkg.sv ====
// Constants and types for the configuration fuse latch.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package fcl_pkg;

  localparam int FCL_NUM_BYTES = 3;
  localparam int FCL_NUM_STAGE = 3;

  // Byte select codes on the programming port
  typedef enum logic [1:0] {
    FCL_SEL_LOW  = 2'h0,
    FCL_SEL_HIGH = 2'h1,
    FCL_SEL_EXT  = 2'h2,
    FCL_SEL_NONE = 2'h3
  } fcl_sel_t;

  // Factory values: a 0 bit is programmed, a 1 bit is unprogrammed
  localparam logic [7:0] FCL_EXT_DEFAULT = 8'hFF;
  localparam logic [7:0] FCL_HIGH_DEFAULT = 8'hD9;
  localparam logic [7:0] FCL_LOW_DEFAULT = 8'h62;
  localparam logic [7:0] FCL_READ_BLANK = 8'hFF;

  // Extended byte fields
  localparam int FCL_EXT_RESET_BEHAV = 5;
  localparam int FCL_EXT_A_LEVEL = 4;
  localparam int FCL_EXT_B_LEVEL = 3;
  localparam int FCL_EXT_BROWNOUT_HI = 2;
  localparam int FCL_EXT_BROWNOUT_LO = 0;

  // High byte fields
  localparam int FCL_HIGH_EXT_RST_DIS = 7;
  localparam int FCL_HIGH_DEBUG_EN = 6;
  localparam int FCL_HIGH_SERIAL_EN = 5;
  localparam int FCL_HIGH_WDOG_ON = 4;
  localparam int FCL_HIGH_EE_KEEP = 3;
  localparam int FCL_HIGH_BOOT_HI = 2;
  localparam int FCL_HIGH_BOOT_LO = 1;
  localparam int FCL_HIGH_VECTOR = 0;

  // Low byte fields
  localparam int FCL_LOW_DIV8 = 7;
  localparam int FCL_LOW_CLK_OUT = 6;
  localparam int FCL_LOW_SUT_HI = 5;
  localparam int FCL_LOW_SUT_LO = 4;
  localparam int FCL_LOW_CKSEL_HI = 3;
  localparam int FCL_LOW_CKSEL_LO = 0;

  // Working configuration as seen by the rest of the device
  typedef struct packed {
    logic [7:0] ext_byte;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } fcl_cfg_t;

  localparam fcl_cfg_t FCL_CFG_DEFAULT = '{
    ext_byte: FCL_EXT_DEFAULT,
    high_byte: FCL_HIGH_DEFAULT,
    low_byte: FCL_LOW_DEFAULT
  };

endpackage

// ==== core/fcl_stage_force.sv ====
// Reset-time forcing of the six power stage outputs.
// Assumes reset and configuration-register write strobes on i_mclk.
`timescale 1ns/1ns
module fcl_stage_force
  import fcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sys_reset,
  input wire logic i_output_cfg_write,
  input wire logic i_pwm_reset_behaviour,
  input wire logic i_a_out_reset_level,
  input wire logic i_b_out_reset_level,
  input wire logic [2*FCL_NUM_STAGE-1:0] i_port_out,
  input wire logic [2*FCL_NUM_STAGE-1:0] i_port_oe,
  output logic [2*FCL_NUM_STAGE-1:0] o_pin_out,
  output logic [2*FCL_NUM_STAGE-1:0] o_pin_oe,
  output logic o_forcing
);

  logic hold_r;
  logic hold_nxt;
  logic force_now;

  // Programmed behaviour fuse (0) arms the hold while reset stands
  always_comb begin
    hold_nxt = hold_r;
    if (i_sys_reset) begin
      hold_nxt = ~i_pwm_reset_behaviour;
    end else if (i_output_cfg_write) begin
      hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // Reset itself forces at once, not a cycle later
  assign force_now = (i_sys_reset & ~i_pwm_reset_behaviour) | (hold_r & ~i_sys_reset);

  ////////////////////////////////////////////////////////////////////////////
  // Pins 0..2 are A-type, 3..5 are B-type
  for (genvar g = 0; g < 2 * FCL_NUM_STAGE; g++) begin : g_pin
    logic level;
    assign level = (g < FCL_NUM_STAGE) ? ~i_a_out_reset_level : ~i_b_out_reset_level;
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        o_pin_out[g] <= 1'b0;
        o_pin_oe[g] <= 1'b0;
      end else if (force_now) begin
        o_pin_out[g] <= level;
        o_pin_oe[g] <= 1'b1;
      end else begin
        o_pin_out[g] <= i_port_out[g];
        o_pin_oe[g] <= i_port_oe[g];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_forcing <= 1'b0;
    end else begin
      o_forcing <= force_now;
    end
  end

  held_until_cfg_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    hold_r && !i_sys_reset && !i_output_cfg_write |=> hold_r)
    else $error("forcing released without a configuration write");

endmodule

// ==== core/fcl_top.sv ====
// Configuration fuse store and working-configuration latch.
// Assumes the programming port and reset strobes run on i_mclk.
`timescale 1ns/1ns
module fcl_top
  import fcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_power_up,
  input wire logic i_sys_reset,
  input wire logic i_prog_mode,
  input wire logic i_prog_serial,
  input wire logic i_fuse_wr,
  input wire logic i_fuse_rd,
  input wire fcl_sel_t i_fuse_sel,
  input wire logic [7:0] i_fuse_wdata,
  input wire logic i_chip_erase,
  input wire logic i_memory_lock_first,
  input wire logic i_output_cfg_write,
  input wire logic [2*FCL_NUM_STAGE-1:0] i_port_out,
  input wire logic [2*FCL_NUM_STAGE-1:0] i_port_oe,
  output logic [7:0] o_fuse_rdata,
  output logic o_fuse_rvalid,
  output logic o_wr_refused,
  output fcl_cfg_t o_cfg,
  output logic o_eeprom_preserve,
  output logic o_clock_out_enable,
  output logic [2*FCL_NUM_STAGE-1:0] o_pin_out,
  output logic [2*FCL_NUM_STAGE-1:0] o_pin_oe,
  output logic o_forcing
);

  ////////////////////////////////////////////////////////////////////////////
  // Fuse storage; i_rst stands for the blank factory state
  logic [7:0] fuse_mem_r [FCL_NUM_BYTES];
  fcl_cfg_t cfg_r;
  logic prog_mode_q_r;
  logic latch_now;
  logic wr_ok;
  logic wr_locked;
  logic [7:0] wdata_eff;
  logic [1:0] sel_idx;

  assign sel_idx = i_fuse_sel;

  // Lock bit follows fuse polarity: 0 means programmed
  assign wr_locked = ~i_memory_lock_first;
  assign wr_ok = i_fuse_wr & i_prog_mode & ~wr_locked & (i_fuse_sel != FCL_SEL_NONE);

  // Serial writes keep the stored serial-enable bit
  always_comb begin
    wdata_eff = i_fuse_wdata;
    if (i_prog_serial && i_fuse_sel == FCL_SEL_HIGH) begin
      wdata_eff[FCL_HIGH_SERIAL_EN] =
        fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_SERIAL_EN];
    end
  end

  // Chip erase is not an input to this store at all
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fuse_mem_r[FCL_SEL_LOW] <= FCL_LOW_DEFAULT;
      fuse_mem_r[FCL_SEL_HIGH] <= FCL_HIGH_DEFAULT;
      fuse_mem_r[FCL_SEL_EXT] <= FCL_EXT_DEFAULT;
    end else if (wr_ok) begin
      fuse_mem_r[sel_idx] <= wdata_eff;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wr_refused <= 1'b0;
    end else begin
      o_wr_refused <= i_fuse_wr & i_prog_mode & wr_locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back: stored bits, so programmed reads 0; serial mode shows the high serial-enable bit as 1
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_fuse_rdata <= FCL_READ_BLANK;
      o_fuse_rvalid <= 1'b0;
    end else begin
      o_fuse_rvalid <= i_fuse_rd & i_prog_mode;
      if (i_fuse_rd && i_prog_mode) begin
        unique case (i_fuse_sel)
          FCL_SEL_LOW: o_fuse_rdata <= fuse_mem_r[FCL_SEL_LOW];
          FCL_SEL_EXT: o_fuse_rdata <= fuse_mem_r[FCL_SEL_EXT];
          FCL_SEL_HIGH: begin
            o_fuse_rdata <= fuse_mem_r[FCL_SEL_HIGH];
            if (i_prog_serial) begin
              o_fuse_rdata[FCL_HIGH_SERIAL_EN] <= 1'b1;
            end
          end
          FCL_SEL_NONE: o_fuse_rdata <= FCL_READ_BLANK;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working copy: latched on power-up outside programming mode, and on programming entry and exit
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prog_mode_q_r <= 1'b0;
    end else begin
      prog_mode_q_r <= i_prog_mode;
    end
  end

  // Exit latch lets writes made while programming take effect afterwards
  assign latch_now = (i_power_up & ~i_prog_mode)
                   | (i_prog_mode ^ prog_mode_q_r);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_r <= FCL_CFG_DEFAULT;
    end else if (latch_now) begin
      cfg_r.ext_byte <= fuse_mem_r[FCL_SEL_EXT];
      cfg_r.high_byte <= fuse_mem_r[FCL_SEL_HIGH];
      cfg_r.low_byte <= fuse_mem_r[FCL_SEL_LOW];
    end
  end

  assign o_cfg = cfg_r;

  // Preserve: programmed store wins at once, no wait for a latch
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_eeprom_preserve <= 1'b0;
    end else begin
      o_eeprom_preserve <= ~(cfg_r.high_byte[FCL_HIGH_EE_KEEP]
                           & fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_EE_KEEP]);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_clock_out_enable <= 1'b0;
    end else begin
      o_clock_out_enable <= ~cfg_r.low_byte[FCL_LOW_CLK_OUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage output forcing uses the latched extended byte only
  fcl_stage_force u_force (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sys_reset(i_sys_reset),
    .i_output_cfg_write(i_output_cfg_write),
    .i_pwm_reset_behaviour(cfg_r.ext_byte[FCL_EXT_RESET_BEHAV]),
    .i_a_out_reset_level(cfg_r.ext_byte[FCL_EXT_A_LEVEL]),
    .i_b_out_reset_level(cfg_r.ext_byte[FCL_EXT_B_LEVEL]),
    .i_port_out(i_port_out),
    .i_port_oe(i_port_oe),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe),
    .o_forcing(o_forcing)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_locked_write;
    i_fuse_wr && i_prog_mode && !i_memory_lock_first;
  endsequence

  // All three bytes, since the select may name no byte at all
  locked_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_locked_write |=> o_wr_refused && $stable(fuse_mem_r[FCL_SEL_LOW])
      && $stable(fuse_mem_r[FCL_SEL_HIGH]) && $stable(fuse_mem_r[FCL_SEL_EXT]))
    else $error("fuse byte changed while locked");

  erase_keeps_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_chip_erase && !i_fuse_wr |=> $stable(fuse_mem_r[FCL_SEL_EXT])
      && $stable(fuse_mem_r[FCL_SEL_HIGH]) && $stable(fuse_mem_r[FCL_SEL_LOW]))
    else $error("chip erase altered a fuse byte");

  serial_hidden_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_rd && i_prog_mode && i_prog_serial && i_fuse_sel == FCL_SEL_HIGH
      |=> o_fuse_rvalid && o_fuse_rdata[FCL_HIGH_SERIAL_EN])
    else $error("serial enable fuse visible in serial mode");

  serial_nowrite_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_prog_serial |=> $stable(fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_SERIAL_EN]))
    else $error("serial enable fuse written in serial mode");

  sequence s_prog_write;
    i_prog_mode && wr_ok ##1 i_prog_mode [*2];
  endsequence

  delayed_effect_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_prog_write |-> $stable(cfg_r))
    else $error("working configuration changed inside programming mode");

  entry_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(i_prog_mode) |=> cfg_r.ext_byte == $past(fuse_mem_r[FCL_SEL_EXT])
      && cfg_r.high_byte == $past(fuse_mem_r[FCL_SEL_HIGH])
      && cfg_r.low_byte == $past(fuse_mem_r[FCL_SEL_LOW]))
    else $error("fuses not latched on programming entry");

  powerup_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_power_up && !i_prog_mode |=> cfg_r.high_byte == $past(fuse_mem_r[FCL_SEL_HIGH]))
    else $error("fuses not latched at power-up");

  preserve_now_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_EE_KEEP] |=> o_eeprom_preserve)
    else $error("EEPROM preserve did not act at once");

  forced_level_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_sys_reset && !cfg_r.ext_byte[FCL_EXT_RESET_BEHAV] && $stable(cfg_r)
      |=> o_forcing && o_pin_oe == '1
      && o_pin_out == {{FCL_NUM_STAGE{!$past(cfg_r.ext_byte[FCL_EXT_B_LEVEL])}},
                       {FCL_NUM_STAGE{!$past(cfg_r.ext_byte[FCL_EXT_A_LEVEL])}}})
    else $error("stage outputs not forced to fuse levels");

  port_pass_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    cfg_r.ext_byte[FCL_EXT_RESET_BEHAV] && $stable(cfg_r) && !o_forcing
      |=> o_pin_out == $past(i_port_out) && o_pin_oe == $past(i_port_oe))
    else $error("stage outputs not behaving as port pins");

  clock_out_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !cfg_r.low_byte[FCL_LOW_CLK_OUT] |=> o_clock_out_enable)
    else $error("clock output not enabled by programmed fuse");

  ////////////////////////////////////////////////////////////////////////////
  // Store and read-back checks

  write_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_wr && i_prog_mode && i_memory_lock_first && i_fuse_sel == FCL_SEL_LOW
      |=> fuse_mem_r[FCL_SEL_LOW] == $past(i_fuse_wdata))
    else $error("low fuse byte write lost");

  write_ext_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_wr && i_prog_mode && i_memory_lock_first && i_fuse_sel == FCL_SEL_EXT
      |=> fuse_mem_r[FCL_SEL_EXT] == $past(i_fuse_wdata))
    else $error("extended fuse byte write lost");

  write_high_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_wr && i_prog_mode && i_memory_lock_first && !i_prog_serial
      && i_fuse_sel == FCL_SEL_HIGH
      |=> fuse_mem_r[FCL_SEL_HIGH] == $past(i_fuse_wdata))
    else $error("high fuse byte write lost");

  // Same-cycle write and read must still return the old byte
  read_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_rd && i_prog_mode && i_fuse_sel == FCL_SEL_LOW
      |=> o_fuse_rvalid && o_fuse_rdata == $past(fuse_mem_r[FCL_SEL_LOW]))
    else $error("low fuse byte read wrong");

  read_ext_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_rd && i_prog_mode && i_fuse_sel == FCL_SEL_EXT
      |=> o_fuse_rvalid && o_fuse_rdata == $past(fuse_mem_r[FCL_SEL_EXT]))
    else $error("extended fuse byte read wrong");

  read_high_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_rd && i_prog_mode && !i_prog_serial && i_fuse_sel == FCL_SEL_HIGH
      |=> o_fuse_rvalid && o_fuse_rdata == $past(fuse_mem_r[FCL_SEL_HIGH]))
    else $error("high fuse byte read wrong");

  read_none_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_rd && i_prog_mode && i_fuse_sel == FCL_SEL_NONE |=> o_fuse_rdata == FCL_READ_BLANK)
    else $error("unselected read not blank");

  rvalid_pulse_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(i_fuse_rd && i_prog_mode) |=> !o_fuse_rvalid && $stable(o_fuse_rdata))
    else $error("read data moved without a read");

  idle_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_fuse_wr && !i_prog_mode |=> !o_wr_refused && $stable(fuse_mem_r[FCL_SEL_LOW])
      && $stable(fuse_mem_r[FCL_SEL_HIGH]) && $stable(fuse_mem_r[FCL_SEL_EXT]))
    else $error("fuse written outside programming mode");

  refused_only_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(i_fuse_wr && i_prog_mode && !i_memory_lock_first) |=> !o_wr_refused)
    else $error("refusal flagged without a locked write");

  ////////////////////////////////////////////////////////////////////////////
  // Latch checks

  cfg_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_power_up || i_prog_mode) && i_prog_mode == prog_mode_q_r |=> $stable(cfg_r))
    else $error("working configuration changed without a latch");

  exit_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_prog_mode && prog_mode_q_r |=> cfg_r.ext_byte == $past(fuse_mem_r[FCL_SEL_EXT])
      && cfg_r.high_byte == $past(fuse_mem_r[FCL_SEL_HIGH])
      && cfg_r.low_byte == $past(fuse_mem_r[FCL_SEL_LOW]))
    else $error("fuses not latched on programming exit");

  preserve_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_EE_KEEP] && cfg_r.high_byte[FCL_HIGH_EE_KEEP]
      |=> !o_eeprom_preserve)
    else $error("EEPROM preserve active while unprogrammed");

  clock_out_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    cfg_r.low_byte[FCL_LOW_CLK_OUT] |=> !o_clock_out_enable)
    else $error("clock output enabled by unprogrammed fuse");

  ////////////////////////////////////////////////////////////////////////////
  // Forcing checks

  forced_oe_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_forcing |-> o_pin_oe == '1)
    else $error("forced stage output not driven");

  sequence s_cfg_release;
    !i_sys_reset && i_output_cfg_write ##1 !i_sys_reset;
  endsequence

  release_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_cfg_release |=> !o_forcing)
    else $error("forcing not released by configuration write");

  forced_reset_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_sys_reset && !cfg_r.ext_byte[FCL_EXT_RESET_BEHAV]) [*2] |-> o_forcing)
    else $error("forcing dropped while reset stands");

  ////////////////////////////////////////////////////////////////////////////
  // Blank-part checks; no disable, the reset is what they watch

  reset_ext_a: assert property (@(posedge i_mclk)
    i_rst |=> &fuse_mem_r[FCL_SEL_EXT])
    else $error("extended byte not blank after reset");

  reset_high_a: assert property (@(posedge i_mclk)
    i_rst |=> !fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_SERIAL_EN]
      && !fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_BOOT_HI]
      && !fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_BOOT_LO]
      && fuse_mem_r[FCL_SEL_HIGH][FCL_HIGH_EE_KEEP])
    else $error("high byte defaults wrong after reset");

  reset_low_a: assert property (@(posedge i_mclk)
    i_rst |=> !fuse_mem_r[FCL_SEL_LOW][FCL_LOW_DIV8]
      && fuse_mem_r[FCL_SEL_LOW][FCL_LOW_CLK_OUT]
      && fuse_mem_r[FCL_SEL_LOW][FCL_LOW_SUT_HI]
      && !fuse_mem_r[FCL_SEL_LOW][FCL_LOW_SUT_LO])
    else $error("low byte defaults wrong after reset");

endmodule

// ==== tb/fcl_port_model.sv ====
// Port-side partner: the normal port logic behind the stage pins.
// Assumes the bench clock and reset; needs nothing else.
`timescale 1ns/1ns
module fcl_port_model
  import fcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  output logic [2*FCL_NUM_STAGE-1:0] o_port_out,
  output logic [2*FCL_NUM_STAGE-1:0] o_port_oe
);
  // Value flips every cycle so a stale pin copy can never match
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_port_out <= 6'h25;
    end else begin
      o_port_out <= ~o_port_out;
    end
  end
  assign o_port_oe = 6'h1B;
endmodule

// ==== tb/fcl_top_tb.sv ====
// Self-checking bench for the configuration fuse latch.
// Assumes the port-side partner model and a 100 MHz clock.
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module fcl_top_tb
  import fcl_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pwr = 1'b0;
  logic sysr = 1'b0;
  logic prog = 1'b0;
  logic ser = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic erase = 1'b0;
  logic lock = 1'b1;
  logic cfgw = 1'b0;
  fcl_sel_t sel = FCL_SEL_NONE;
  logic [7:0] wd = 8'h00;
  logic [5:0] port_out, port_oe, pin_out, pin_oe;
  logic [7:0] rdata;
  logic rvalid, refused, preserve, clk_out, forcing, ref_seen;
  fcl_cfg_t cfg;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] ext_tab [5] = '{8'hFF, 8'hCF, 8'hD7, 8'hC7, 8'hDF};

  always #5 mclk = ~mclk;

  fcl_port_model fcl_port_model_i (.i_mclk(mclk), .i_rst(rst), .o_port_out(port_out),
    .o_port_oe(port_oe));

  fcl_top fcl_top_i (.i_mclk(mclk), .i_rst(rst), .i_power_up(pwr), .i_sys_reset(sysr),
    .i_prog_mode(prog), .i_prog_serial(ser), .i_fuse_wr(wr), .i_fuse_rd(rd),
    .i_fuse_sel(sel), .i_fuse_wdata(wd), .i_chip_erase(erase),
    .i_memory_lock_first(lock), .i_output_cfg_write(cfgw), .i_port_out(port_out),
    .i_port_oe(port_oe), .o_fuse_rdata(rdata), .o_fuse_rvalid(rvalid),
    .o_wr_refused(refused), .o_cfg(cfg), .o_eeprom_preserve(preserve),
    .o_clock_out_enable(clk_out), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_forcing(forcing));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Extra cycle at the end keeps back-to-back strobes from colliding
  task automatic wr_fuse(input fcl_sel_t s, input logic [7:0] d);
    wr = 1'b1;
    sel = s;
    wd = d;
    tick(1);
    wr = 1'b0;
    ref_seen = refused;
    tick(1);
  endtask

  task automatic rd_fuse(input fcl_sel_t s, input logic [7:0] exp);
    rd = 1'b1;
    sel = s;
    tick(1);
    rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, exp)
    tick(1);
  endtask

  task automatic prog_set(input logic p, input logic s);
    prog = p;
    ser = s;
    tick(4);
  endtask

  task automatic end_sim();
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang should never pass quietly; the sequence needs well under 1000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst = 1'b0;
    tick(2);
    `CHK(cfg, {8'hFF, 8'hD9, 8'h62})
    `CHK(preserve, 1'b0)
    `CHK(clk_out, 1'b0)
    `CHK(pin_out, ~port_out)
    `CHK(pin_oe, port_oe)
    wr_fuse(FCL_SEL_LOW, 8'h00);
    prog_set(1'b1, 1'b0);
    rd_fuse(FCL_SEL_EXT, 8'hFF);
    rd_fuse(FCL_SEL_HIGH, 8'hD9);
    rd_fuse(FCL_SEL_LOW, 8'h62);
    rd_fuse(FCL_SEL_NONE, 8'hFF);
    wr_fuse(FCL_SEL_NONE, 8'h00);
    wr_fuse(FCL_SEL_HIGH, 8'hD1);
    `CHK(preserve, 1'b1)
    `CHK(cfg.high_byte, 8'hD9)
    wr_fuse(FCL_SEL_LOW, 8'h22);
    rd_fuse(FCL_SEL_LOW, 8'h22);
    erase = 1'b1;
    tick(1);
    erase = 1'b0;
    tick(1);
    rd_fuse(FCL_SEL_HIGH, 8'hD1);
    rd_fuse(FCL_SEL_EXT, 8'hFF);
    pwr = 1'b1;
    tick(1);
    pwr = 1'b0;
    tick(2);
    `CHK(cfg.low_byte, 8'h62)
    prog_set(1'b0, 1'b0);
    `CHK(cfg, {8'hFF, 8'hD1, 8'h22})
    `CHK(clk_out, 1'b1)
    pwr = 1'b1;
    tick(1);
    pwr = 1'b0;
    tick(2);
    `CHK(cfg, {8'hFF, 8'hD1, 8'h22})
    // Serial pass: the serial enable bit stays hidden and untouched
    prog_set(1'b1, 1'b1);
    wr_fuse(FCL_SEL_HIGH, 8'hF9);
    rd_fuse(FCL_SEL_HIGH, 8'hF9);
    ser = 1'b0;
    tick(1);
    rd_fuse(FCL_SEL_HIGH, 8'hD9);
    // Lock on: a low-byte write is refused and the byte reads back unchanged
    lock = 1'b0;
    tick(1);
    wr_fuse(FCL_SEL_LOW, 8'hFF);
    `CHK(ref_seen, 1'b1)
    rd_fuse(FCL_SEL_LOW, 8'h22);
    lock = 1'b1;
    prog_set(1'b0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      prog_set(1'b1, 1'b0);
      wr_fuse(FCL_SEL_EXT, ext_tab[i]);
      prog_set(1'b0, 1'b0);
      sysr = 1'b1;
      tick(3);
      cfgw = 1'b1;
      tick(1);
      cfgw = 1'b0;
      tick(1);
      if (ext_tab[i][5] == 1'b0) begin
        `CHK(pin_out, {{3{~ext_tab[i][3]}}, {3{~ext_tab[i][4]}}})
        `CHK(pin_oe, 6'h3F)
      end else begin
        `CHK(pin_out, ~port_out)
      end
      `CHK(forcing, ~ext_tab[i][5])
      sysr = 1'b0;
      tick(3);
      `CHK(forcing, ~ext_tab[i][5])
      cfgw = 1'b1;
      tick(1);
      cfgw = 1'b0;
      tick(3);
      `CHK(forcing, 1'b0)
      `CHK(pin_out, ~port_out)
      `CHK(pin_oe, port_oe)
    end
    end_sim();
  end
endmodule
